// ==== design/rtc_alarm_cfg.svh ====
`ifndef RTC_ALARM_CFG_SVH
`define RTC_ALARM_CFG_SVH
// register byte offsets on the wishbone window
`define RTC_OFS_ALARM_BASE 8'h00
`define RTC_OFS_FLAG_CTRL 8'h14
`define RTC_OFS_PERIOD_CTRL 8'h18
// alarm register layout
`define RTC_ENB_BIT 7
`define RTC_MASK_MINUTE 8'h7f
`define RTC_MASK_HOUR 8'h3f
`define RTC_MASK_WEEKDAY 8'h07
`define RTC_MASK_DATE 8'h3f
`define RTC_MASK_MONTH 8'h1f
// flag and interrupt control layout
`define RTC_CF_BIT 7
`define RTC_CIE_BIT 4
`define RTC_AIE_BIT 3
`define RTC_AF_BIT 0
`define RTC_CTRL1_RST 8'h00
// period and run control layout
`define RTC_PEF_BIT 7
`define RTC_PES_LSB 4
`define RTC_OSC_BIT 3
`define RTC_ADJ_BIT 2
`define RTC_DRST_BIT 1
`define RTC_START_BIT 0
`define RTC_CTRL2_RST 8'h09
`endif

// ==== design/rtc_alarm_pkg.sv ====
package rtc_alarm_pkg;
   // bcd calendar values from the counter chain
   typedef struct packed {
      logic [7:0] minute;
      logic [7:0] hour;
      logic [7:0] weekday;
      logic [7:0] date;
      logic [7:0] month;
   } calendar_t;
   // one pulse per divider tap: 256, 64, 16, 4, 2 and 1 hz
   typedef struct packed {
      logic hz1;
      logic hz2;
      logic hz4;
      logic hz16;
      logic hz64;
      logic hz256;
   } tap_t;
   // periodic select codes
   typedef enum logic [2:0] {
      per_none, per_256, per_64, per_16, per_4, per_2, per_1s, per_2s
   } period_sel_t;
endpackage

// ==== design/rtc_period_tick.sv ====
`timescale 1ns/1ps
module rtc_period_tick #(
   parameter int unsigned N_TAPS = 6
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // selection and taps
   input wire rtc_alarm_pkg::period_sel_t sel_i,
   input wire rtc_alarm_pkg::tap_t tap_i,
   // one pulse each elapsed interval
   output logic pulse_o
);
   import rtc_alarm_pkg::*;

   // the tap structure fixes the tap count
   if (N_TAPS != 6) begin : g_bad_taps
      $error("rtc_period_tick serves exactly six divider taps");
   end

   logic half_ff; // second half of a two second interval
   logic nxt_pulse;

   // two second interval: every other one hertz tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         half_ff <= 1'b0;
      end else if (tap_i.hz1) begin
         half_ff <= ~half_ff;
      end
   end

   // pick the tap that the select field names
   always_comb begin
      unique case (sel_i)
         per_none: nxt_pulse = 1'b0;
         per_256:  nxt_pulse = tap_i.hz256;
         per_64:   nxt_pulse = tap_i.hz64;
         per_16:   nxt_pulse = tap_i.hz16;
         per_4:    nxt_pulse = tap_i.hz4;
         per_2:    nxt_pulse = tap_i.hz2;
         per_1s:   nxt_pulse = tap_i.hz1;
         per_2s:   nxt_pulse = tap_i.hz1 & half_ff;
      endcase
   end

   assign pulse_o = nxt_pulse;
endmodule

// ==== design/rtc_alarm_ctrl.sv ====
// Notes on behaviour
// - alarm when all enabled fields match
// - weekday code bits 2:0, 6:3 zero
// - power-on clears enables; fields otherwise kept
// - control one clears on resets, carry kept
// - carry flag set on read during carry
// - writing zero clears the carry flag
// - carry interrupt while flag and enable
// - alarm interrupt while flag and enable
// - alarm flag: zero clears, one keeps
// - control one bits 6,5,2,1 read zero
// - control two 0x09; manual keeps osc, start
// - periodic flag interrupts; zero clears it
// - select field picks periodic interval
// - bit 3 controls the crystal oscillator
// - oscillator enable: 0 halts, resets to 1
// - adjust write rounds seconds, resets divider
// - count start gates second..year counters
// - periodic flag set each interval elapsed
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "rtc_alarm_cfg.svh"
module rtc_alarm_ctrl #(
   parameter int unsigned N_ALARMS = 5
) (
   // clock and power-on reset
   input wire logic clk_i,
   input wire logic rst_i,
   // manual reset, synchronous to clk_i
   input wire logic manual_rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // calendar chain
   input wire rtc_alarm_pkg::calendar_t calendar_i,
   input wire logic sec_alarm_en_i,
   input wire logic sec_alarm_hit_i,
   input wire logic counter_read_i,
   input wire logic carry_sub_i,
   input wire logic carry_sec_i,
   input wire rtc_alarm_pkg::tap_t tap_i,
   // run control towards the chain
   output logic oscillator_enable_o,
   output logic count_start_o,
   output logic thirty_second_adjust_o,
   output logic divider_reset_o,
   // level interrupts
   output logic alarm_irq_o,
   output logic carry_irq_o,
   output logic periodic_irq_o
);
   import rtc_alarm_pkg::*;

   // five alarm registers fill five aligned words
   if (N_ALARMS != 5) begin : g_bad_alarms
      $error("rtc_alarm_ctrl serves exactly five alarm registers");
   end

   localparam logic [7:0] FIELD_MASK [5] = '{`RTC_MASK_MINUTE, `RTC_MASK_HOUR,
      `RTC_MASK_WEEKDAY, `RTC_MASK_DATE, `RTC_MASK_MONTH};

   // one alarm field passes when disabled or equal to its counter
   function automatic logic field_ok(input logic [7:0] al, input logic [7:0] cnt,
                                     input logic [7:0] mask);
      field_ok = ~al[`RTC_ENB_BIT] | ((al & mask) == (cnt & mask));
   endfunction

   // word decode of a byte address
   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
      reg_hit = (adr[7:2] == ofs[7:2]);
   endfunction

   logic [7:0] alarm_ff [5]; // alarm registers, enable in bit 7
   logic carry_flag_ff; // carry during counter read
   logic carry_irq_enable_ff;
   logic alarm_irq_enable_ff;
   logic alarm_flag_ff;
   logic periodic_flag_ff;
   period_sel_t periodic_select_ff;
   logic oscillator_enable_ff;
   logic count_start_ff;
   logic adjust_ff; // one-cycle pulses
   logic div_reset_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic match_prev_ff; // match seen last clock
   logic [7:0] cal_vals [5];
   logic [7:0] nxt_rdata;
   logic wr_commit; // write takes effect at the acked edge
   logic wr_ctrl1;
   logic wr_ctrl2;
   logic any_enabled;
   logic all_match;
   logic match_now;
   logic period_pulse;
   logic carry_event;

   assign cal_vals = '{calendar_i.minute, calendar_i.hour, calendar_i.weekday,
                       calendar_i.date, calendar_i.month};
   assign wr_commit = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & wb_sel_i[0];
   assign wr_ctrl1 = wr_commit & reg_hit(wb_adr_i, `RTC_OFS_FLAG_CTRL);
   assign wr_ctrl2 = wr_commit & reg_hit(wb_adr_i, `RTC_OFS_PERIOD_CTRL);

   // bus answer: ack one cycle after the request, then drop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
      end
   end

   // read mux, reserved and unmapped reads give zero
   always_comb begin
      nxt_rdata = 8'h00;
      for (int i = 0; i < 5; i++) begin
         if (reg_hit(wb_adr_i, 8'(`RTC_OFS_ALARM_BASE + 4 * i))) begin
            nxt_rdata = alarm_ff[i] & (FIELD_MASK[i] | 8'h80);
         end
      end
      if (reg_hit(wb_adr_i, `RTC_OFS_FLAG_CTRL)) begin
         nxt_rdata = {carry_flag_ff, 2'b00, carry_irq_enable_ff,
                      alarm_irq_enable_ff, 2'b00, alarm_flag_ff};
      end
      if (reg_hit(wb_adr_i, `RTC_OFS_PERIOD_CTRL)) begin
         // adjust and divider reset read as zero
         nxt_rdata = {periodic_flag_ff, periodic_select_ff, oscillator_enable_ff,
                      2'b00, count_start_ff};
      end
   end

   // read data captured with the ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_ff <= 32'h0000_0000;
      end else if (wb_cyc_i & wb_stb_i & ~ack_ff) begin
         dat_ff <= {24'h00_0000, nxt_rdata};
      end
   end

   // alarm registers: only enables see power-on reset
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 5; i++) begin
         if (rst_i) begin
            alarm_ff[i][`RTC_ENB_BIT] <= 1'b0;
         end else if (wr_commit && reg_hit(wb_adr_i, 8'(`RTC_OFS_ALARM_BASE + 4 * i))) begin
            alarm_ff[i] <= wb_dat_i[7:0] & (FIELD_MASK[i] | 8'h80);
         end
      end
   end

   // comparison of enabled fields, second alarm from outside
   always_comb begin
      all_match = ~sec_alarm_en_i | sec_alarm_hit_i;
      any_enabled = sec_alarm_en_i;
      for (int i = 0; i < 5; i++) begin
         all_match = all_match & field_ok(alarm_ff[i], cal_vals[i], FIELD_MASK[i]);
         any_enabled = any_enabled | alarm_ff[i][`RTC_ENB_BIT];
      end
   end
   assign match_now = all_match & any_enabled;

   // edge of the match
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         match_prev_ff <= 1'b0;
      end else begin
         match_prev_ff <= match_now;
      end
   end

   // alarm flag: set on first match clock, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i || manual_rst_i) begin
         alarm_flag_ff <= 1'b0;
      end else if (match_now && !match_prev_ff) begin
         alarm_flag_ff <= 1'b1;
      end else if (wr_ctrl1 && !wb_dat_i[`RTC_AF_BIT]) begin
         alarm_flag_ff <= 1'b0;
      end
   end

   // carry flag: kept through manual reset
   assign carry_event = counter_read_i & (carry_sub_i | carry_sec_i);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         carry_flag_ff <= 1'b0;
      end else if (carry_event) begin
         carry_flag_ff <= 1'b1;
      end else if (wr_ctrl1 && !wb_dat_i[`RTC_CF_BIT]) begin
         carry_flag_ff <= 1'b0;
      end
   end

   // interrupt enables of control one
   always_ff @(posedge clk_i) begin
      if (rst_i || manual_rst_i) begin
         carry_irq_enable_ff <= 1'(`RTC_CTRL1_RST >> `RTC_CIE_BIT);
         alarm_irq_enable_ff <= 1'(`RTC_CTRL1_RST >> `RTC_AIE_BIT);
      end else if (wr_ctrl1) begin
         carry_irq_enable_ff <= wb_dat_i[`RTC_CIE_BIT];
         alarm_irq_enable_ff <= wb_dat_i[`RTC_AIE_BIT];
      end
   end

   // periodic interval selection
   rtc_period_tick #(
      .N_TAPS(6)
   ) u_period (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sel_i(periodic_select_ff),
      .tap_i(tap_i),
      .pulse_o(period_pulse)
   );

   // periodic flag, set wins over a zero write
   always_ff @(posedge clk_i) begin
      if (rst_i || manual_rst_i) begin
         periodic_flag_ff <= 1'(`RTC_CTRL2_RST >> `RTC_PEF_BIT);
      end else if (period_pulse) begin
         periodic_flag_ff <= 1'b1;
      end else if (wr_ctrl2 && !wb_dat_i[`RTC_PEF_BIT]) begin
         periodic_flag_ff <= 1'b0;
      end
   end

   // periodic select, cleared by either reset
   always_ff @(posedge clk_i) begin
      if (rst_i || manual_rst_i) begin
         periodic_select_ff <= per_none;
      end else if (wr_ctrl2) begin
         periodic_select_ff <= period_sel_t'(wb_dat_i[`RTC_PES_LSB +: 3]);
      end
   end

   // oscillator and run bits survive manual reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oscillator_enable_ff <= 1'(`RTC_CTRL2_RST >> `RTC_OSC_BIT);
         count_start_ff <= 1'(`RTC_CTRL2_RST >> `RTC_START_BIT);
      end else if (wr_ctrl2) begin
         oscillator_enable_ff <= wb_dat_i[`RTC_OSC_BIT];
         count_start_ff <= wb_dat_i[`RTC_START_BIT];
      end
   end

   // adjust and divider reset strobes, never stored
   always_ff @(posedge clk_i) begin
      if (rst_i || manual_rst_i) begin
         adjust_ff <= 1'b0;
         div_reset_ff <= 1'b0;
      end else begin
         adjust_ff <= wr_ctrl2 & wb_dat_i[`RTC_ADJ_BIT];
         div_reset_ff <= wr_ctrl2 & (wb_dat_i[`RTC_ADJ_BIT] | wb_dat_i[`RTC_DRST_BIT]);
      end
   end

   // outputs
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign oscillator_enable_o = oscillator_enable_ff;
   assign count_start_o = count_start_ff;
   assign thirty_second_adjust_o = adjust_ff;
   assign divider_reset_o = div_reset_ff;
   assign alarm_irq_o = alarm_flag_ff & alarm_irq_enable_ff;
   assign carry_irq_o = carry_flag_ff & carry_irq_enable_ff;
   assign periodic_irq_o = periodic_flag_ff;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // match edge raises the flag next clock
   alarm_set_a: assert property (match_now && !match_prev_ff && !manual_rst_i
      |=> alarm_flag_ff) else $error("alarm flag not set on match");
   // writing one keeps the flag
   alarm_hold_a: assert property (alarm_flag_ff && !manual_rst_i
      && !(wr_ctrl1 && !wb_dat_i[0]) |=> alarm_flag_ff) else $error("alarm flag lost");
   // zero write clears absent a new match
   alarm_clear_a: assert property (wr_ctrl1 && !wb_dat_i[0] && !(match_now && !match_prev_ff)
      |=> !alarm_flag_ff) else $error("alarm flag not cleared");
   // carry seen during read is flagged next clock, irq then equals the enable
   carry_set_a: assert property (carry_event |=> carry_flag_ff [*1] ##0
      (carry_irq_enable_ff == carry_irq_o)) else $error("carry flag missed");
   // disabled alarm interrupt stays low
   alarm_irq_a: assert property (!alarm_irq_enable_ff |-> !alarm_irq_o)
      else $error("alarm irq without enable");
   // periodic tick sets the flag and interrupt
   periodic_set_a: assert property (period_pulse && !manual_rst_i
      |=> periodic_flag_ff && periodic_irq_o) else $error("periodic flag missed");
   // manual reset keeps oscillator and start
   manual_ctrl2_a: assert property (manual_rst_i && !wr_ctrl2 |=>
      $stable(oscillator_enable_ff) && $stable(count_start_ff) && !periodic_flag_ff
      && periodic_select_ff == per_none) else $error("manual reset of control two");
   // manual reset clears control one but the carry flag
   manual_ctrl1_a: assert property (manual_rst_i && !carry_event && !wr_ctrl1 |=>
      !alarm_irq_enable_ff && !carry_irq_enable_ff && $stable(carry_flag_ff))
      else $error("manual reset of control one");
   // reserved bits of control one read zero
   reserved_zero_a: assert property (ack_ff && reg_hit(wb_adr_i, `RTC_OFS_FLAG_CTRL)
      |-> wb_dat_o[6:5] == 2'b00 && wb_dat_o[2:1] == 2'b00) else $error("reserved bit set");
   // adjust write pulses adjust and divider reset once
   adjust_a: assert property (wr_ctrl2 && wb_dat_i[2] && !manual_rst_i
      |=> thirty_second_adjust_o && divider_reset_o ##1 !thirty_second_adjust_o)
      else $error("adjust strobe wrong");
   // power-on reset values
   por_values_a: assert property (@(posedge clk_i) disable iff (1'b0) rst_i
      |=> !alarm_ff[0][7] && !alarm_ff[4][7] && oscillator_enable_ff && count_start_ff)
      else $error("power-on values wrong");

   alarm_irq_c: cover property (alarm_irq_o);
   carry_irq_c: cover property (carry_irq_o);
   period_2s_c: cover property (period_pulse && periodic_select_ff == per_2s);
   adjust_c: cover property (thirty_second_adjust_o);
endmodule

// ==== sim/rtc_alarm_and_interrupt_control_bench.sv ====
`timescale 1ns/1ps
`include "rtc_alarm_cfg.svh"
module rtc_alarm_and_interrupt_control_bench;
   import rtc_alarm_pkg::*;
   // table row: address, write value, expected read-back
   typedef struct {logic [7:0] adr; logic [7:0] wd; logic [7:0] exp;} row_t;
   // clock and resets
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic manual_rst_i = 1'b0;
   // bus master side
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   // calendar chain stimulus
   calendar_t calendar_i = '0;
   logic sec_alarm_en_i = 1'b0;
   logic sec_alarm_hit_i = 1'b0;
   logic counter_read_i = 1'b0;
   logic carry_sub_i = 1'b0;
   logic carry_sec_i = 1'b0;
   tap_t tap_i = '0;
   // design outputs
   logic oscillator_enable_o, count_start_o, thirty_second_adjust_o, divider_reset_o;
   logic alarm_irq_o, carry_irq_o, periodic_irq_o;
   // bookkeeping
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   int adj_cnt = 0;
   int drst_cnt = 0;
   // every mapped register plus one unmapped word, legal bcd values only
   row_t rows [8] = '{'{8'h00, 8'hd9, 8'hd9}, '{8'h04, 8'ha3, 8'ha3},
      '{8'h08, 8'h86, 8'h86}, '{8'h0c, 8'hb1, 8'hb1}, '{8'h10, 8'h92, 8'h92},
      '{8'h14, 8'h18, 8'h18}, '{8'h18, 8'hff, 8'h79}, '{8'h1c, 8'hff, 8'h00}};

   // 50 mhz clock
   always #10 clk_i = ~clk_i;

   rtc_alarm_ctrl rtc_alarm_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .manual_rst_i(manual_rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .calendar_i(calendar_i), .sec_alarm_en_i(sec_alarm_en_i),
      .sec_alarm_hit_i(sec_alarm_hit_i), .counter_read_i(counter_read_i),
      .carry_sub_i(carry_sub_i), .carry_sec_i(carry_sec_i), .tap_i(tap_i),
      .oscillator_enable_o(oscillator_enable_o), .count_start_o(count_start_o),
      .thirty_second_adjust_o(thirty_second_adjust_o), .divider_reset_o(divider_reset_o),
      .alarm_irq_o(alarm_irq_o), .carry_irq_o(carry_irq_o), .periodic_irq_o(periodic_irq_o));

   // verdict and end of run
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // compare seen against expected
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one classic cycle, held until ack is seen, then one idle cycle
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                       output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h0, wd};
      @(posedge clk_i);
      // ack and read data are taken at the rising edge that sees ack high
      while (wb_ack_o !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk_i);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (n >= 50) begin
         chk("ack wait", 32'h0, 32'h1);
      end
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      logic [31:0] x;
      xfer(1'b1, adr, d, x);
   endtask

   task automatic rdc(input string what, input logic [7:0] adr, input logic [7:0] exp);
      logic [31:0] x;
      xfer(1'b0, adr, 8'h00, x);
      chk(what, x, {24'h0, exp});
   endtask

   // counter read with optional carries, then settle
   task automatic carry_read(input logic sub, input logic sec);
      counter_read_i <= 1'b1;
      carry_sub_i <= sub;
      carry_sec_i <= sec;
      @(posedge clk_i);
      counter_read_i <= 1'b0;
      carry_sub_i <= 1'b0;
      carry_sec_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   // single divider tap pulse
   task automatic tap_pulse(input int b);
      tap_i <= tap_t'(6'h01 << b);
      @(posedge clk_i);
      tap_i <= '0;
      repeat (2) @(posedge clk_i);
   endtask

   // pulse counters and hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (thirty_second_adjust_o === 1'b1) begin
         adj_cnt <= adj_cnt + 1;
      end
      if (divider_reset_o === 1'b1) begin
         drst_cnt <= drst_cnt + 1;
      end
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end

   initial begin
      int a0;
      int d0;
      logic [31:0] x;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // power-on values
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, 8'(4 * i), 8'h00, x);
         chk("alarm enable", x & 32'h80, 32'h0);
      end
      rdc("flag ctrl reset", `RTC_OFS_FLAG_CTRL, 8'h00);
      rdc("period ctrl reset", `RTC_OFS_PERIOD_CTRL, 8'h09);
      chk("outputs reset", {alarm_irq_o, carry_irq_o, periodic_irq_o, oscillator_enable_o,
          count_start_o}, 32'h03);
      // read-back table
      foreach (rows[i]) begin
         wr(rows[i].adr, rows[i].wd);
         rdc("table", rows[i].adr, rows[i].exp);
      end
      // alarm on minute and hour only
      wr(8'h00, 8'hb0);
      wr(8'h04, 8'h92);
      wr(8'h08, 8'h00);
      wr(8'h0c, 8'h01);
      wr(8'h10, 8'h01);
      wr(`RTC_OFS_PERIOD_CTRL, 8'h09);
      wr(`RTC_OFS_FLAG_CTRL, 8'h08);
      calendar_i <= '{8'h30, 8'h11, 8'h03, 8'h01, 8'h01};
      repeat (3) @(posedge clk_i);
      chk("partial match", alarm_irq_o, 32'h0);
      calendar_i.hour <= 8'h12;
      repeat (3) @(posedge clk_i);
      chk("alarm irq", alarm_irq_o, 32'h1);
      rdc("alarm flag", `RTC_OFS_FLAG_CTRL, 8'h09);
      wr(`RTC_OFS_FLAG_CTRL, 8'h09);
      rdc("alarm flag one kept", `RTC_OFS_FLAG_CTRL, 8'h09);
      wr(`RTC_OFS_FLAG_CTRL, 8'h08);
      rdc("alarm flag cleared", `RTC_OFS_FLAG_CTRL, 8'h08);
      chk("alarm irq cleared", alarm_irq_o, 32'h0);
      // weekday enabled and mismatching, then matching, irq masked
      wr(`RTC_OFS_FLAG_CTRL, 8'h00);
      wr(8'h08, 8'h85);
      calendar_i.hour <= 8'h11;
      @(posedge clk_i);
      calendar_i.hour <= 8'h12;
      repeat (3) @(posedge clk_i);
      rdc("weekday mismatch", `RTC_OFS_FLAG_CTRL, 8'h00);
      calendar_i.weekday <= 8'h05;
      repeat (3) @(posedge clk_i);
      rdc("all fields match", `RTC_OFS_FLAG_CTRL, 8'h01);
      chk("alarm irq masked", alarm_irq_o, 32'h0);
      // second alarm enabled from the chain: no hit breaks the match, a hit restores it
      sec_alarm_en_i <= 1'b1;
      wr(`RTC_OFS_FLAG_CTRL, 8'h00);
      rdc("second alarm miss", `RTC_OFS_FLAG_CTRL, 8'h00);
      sec_alarm_hit_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rdc("second alarm hit", `RTC_OFS_FLAG_CTRL, 8'h01);
      // carry flag
      wr(`RTC_OFS_FLAG_CTRL, 8'h10);
      carry_read(1'b0, 1'b0);
      chk("no carry", carry_irq_o, 32'h0);
      carry_read(1'b0, 1'b1);
      chk("carry irq", carry_irq_o, 32'h1);
      rdc("carry flag", `RTC_OFS_FLAG_CTRL, 8'h90);
      wr(`RTC_OFS_FLAG_CTRL, 8'h00);
      rdc("carry cleared", `RTC_OFS_FLAG_CTRL, 8'h00);
      carry_read(1'b1, 1'b0);
      chk("carry irq disabled", carry_irq_o, 32'h0);
      rdc("sub carry flag", `RTC_OFS_FLAG_CTRL, 8'h80);
      // periodic select: none never fires
      wr(`RTC_OFS_PERIOD_CTRL, 8'h09);
      for (int b = 0; b < 6; b++) tap_pulse(b);
      chk("select none", periodic_irq_o, 32'h0);
      for (int s = 1; s < 8; s++) begin
         wr(`RTC_OFS_PERIOD_CTRL, {1'b0, 3'(s), 4'h9});
         tap_pulse(s % 6);
         chk("wrong tap", periodic_irq_o, 32'h0);
         tap_pulse(s == 7 ? 5 : s - 1);
         if (s == 7) begin
            tap_pulse(5);
         end
         chk("periodic irq", periodic_irq_o, 32'h1);
         wr(`RTC_OFS_PERIOD_CTRL, {1'b0, 3'(s), 4'h9});
         chk("periodic cleared", periodic_irq_o, 32'h0);
      end
      // two second select: the sixth one hertz tick since reset fires, the seventh not
      tap_pulse(5);
      chk("two second tick", periodic_irq_o, 32'h1);
      wr(`RTC_OFS_PERIOD_CTRL, 8'h79);
      tap_pulse(5);
      chk("two second gap", periodic_irq_o, 32'h0);
      // adjust, divider reset, oscillator and start
      a0 = adj_cnt;
      d0 = drst_cnt;
      wr(`RTC_OFS_PERIOD_CTRL, 8'h0d);
      repeat (2) @(posedge clk_i);
      chk("adjust pulses", adj_cnt - a0, 32'h1);
      chk("divider pulses", drst_cnt - d0, 32'h1);
      wr(`RTC_OFS_PERIOD_CTRL, 8'h0b);
      repeat (2) @(posedge clk_i);
      chk("adjust pulses", adj_cnt - a0, 32'h1);
      chk("divider pulses", drst_cnt - d0, 32'h2);
      wr(`RTC_OFS_PERIOD_CTRL, 8'h70);
      chk("osc and start off", {oscillator_enable_o, count_start_o}, 32'h0);
      // manual reset keeps carry, osc, start and alarm fields
      // lane 0 off: the write is acked but ignored
      wb_sel_i <= 4'he;
      wr(8'h00, 8'h59);
      wb_sel_i <= 4'hf;
      // whole-value write, carry written as one so it stays set
      wr(`RTC_OFS_FLAG_CTRL, 8'h98);
      manual_rst_i <= 1'b1;
      @(posedge clk_i);
      manual_rst_i <= 1'b0;
      @(posedge clk_i);
      rdc("flag ctrl manual", `RTC_OFS_FLAG_CTRL, 8'h80);
      rdc("period ctrl manual", `RTC_OFS_PERIOD_CTRL, 8'h00);
      rdc("minute alarm kept", 8'h00, 8'hb0);
      rdc("weekday alarm kept", 8'h08, 8'h85);
      wr(`RTC_OFS_FLAG_CTRL, 8'h00);
      rdc("carry cleared", `RTC_OFS_FLAG_CTRL, 8'h00);
      print_verdict();
   end
endmodule
